// *** verilog/cap_measure.sv ***
/*
 * electrode capacitance measurement sequencer with global and per-electrode
 * charge settings and a simple register port.
 * assumes analog switches, current source and converter outside.
 */
// Overview of operation
// [R1] ground the selected electrode, then charge it at constant current for charge time
// [R2] all other electrodes stay grounded during charge and measurement
// [R3] at end of charge time convert electrode voltage to a 10-bit sample
// [R4] discharge afterwards with the same current and duration as charging
// [R5] front-end configuration register sits at address 0x5c
// [R6] front-end bits 7:6 pick first filter samples 6, 10, 18, 34
// [R7] front-end bits 5:0 set current in microamps; zero disables charging
// [R8] filter bits 7:5 set charge time 0.5 us to 32 us; zero invalid
// [R9] filter bits 4:3 pick second filter samples 4, 6, 10, 18
// [R10] filter bits 2:0 set sample interval 1 ms to 128 ms
// [R11] global settings apply to all electrodes unless individually overridden
// [R12] per-electrode charge-time code zero falls back to the global time
// [R13] charge-time and interval codes double the duration per step
// [R14] electrodes measured one at a time, each finishing all phases first
`timescale 1ns/1ps
module cap_measure
    import cap_measure_pkg::*;
#(
    parameter int NUM_ELEC             = 12,
    parameter int INTERVAL_BASE_CYCLES_P = INTERVAL_BASE_CYCLES
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic [7:0]               reg_rdata,
    // electrode switches and current source
    output logic [NUM_ELEC-1:0]      elec_ground,
    output logic [3:0]               elec_select,
    output logic                     charge_en,
    output logic                     discharge_en,
    output logic [5:0]               charge_current_select,
    // converter pins
    output logic                     adc_start,
    input  wire logic                adc_done,
    input  wire logic [9:0]          adc_data,
    // filter settings and scan status
    output logic [5:0]               first_filter_sample_count,
    output logic [5:0]               second_filter_sample_count,
    output logic                     scan_done
);

    typedef struct packed {
        meas_state_t                   st;
        logic [3:0]                    elec;
        logic [15:0]                   timer;
        logic [15:0]                   phase_cycles;
        logic [31:0]                   interval;
        logic                          pending;
        logic [7:0]                    front_end_config;
        logic [7:0]                    filter_config;
        logic [NUM_ELEC-1:0][5:0]      elec_current;
        logic [NUM_ELEC-1:0][2:0]      elec_time;
        logic [NUM_ELEC-1:0][9:0]      samples;
        logic [5:0]                    current;
        logic [NUM_ELEC-1:0]           ground;
        logic                          charge;
        logic                          discharge;
        logic                          start;
        logic                          done;
        logic [7:0]                    rdata;
        logic [5:0]                    ffi_count;
        logic [5:0]                    sfi_count;
    } meas_reg_t;

    meas_reg_t state_reg;
    meas_reg_t state_next;

    conv_if cv ();

    conv_capture u_conv (
        .clk       (clk),
        .reset     (reset),
        .cv        (cv.conv),
        .adc_start (adc_start),
        .adc_done  (adc_done),
        .adc_data  (adc_data)
    );

    // ==========================================================
    // helpers
    function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base, input int n);
        in_block = (addr >= base) && ({24'h0, addr} < {24'h0, base} + 32'(n));
    endfunction : in_block

    function automatic logic [3:0] block_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d         = addr - base;
        block_idx = d[3:0];
    endfunction : block_idx

    // code 0 of the global field is invalid; run it as the shortest time
    function automatic logic [15:0] charge_cycles(input logic [2:0] code);
        logic [2:0] sh;
        sh            = (code == 3'd0) ? 3'd0 : code - 3'd1;
        charge_cycles = 16'(CHARGE_BASE_CYCLES) << sh; // R8 R13
    endfunction : charge_cycles

    logic [2:0]  elec_time_code;
    logic [5:0]  elec_cur_code;
    logic [31:0] interval_cycles;
    logic [7:0]  sample_off;
    logic [3:0]  sample_idx;
    logic        tick;

    // ==========================================================
    // next state
    always_comb begin
        state_next      = state_reg;
        state_next.start = 1'b0;
        state_next.done  = 1'b0;
        sample_off       = 8'h00;
        sample_idx       = 4'h0;

        // per-electrode override, zero keeps global
        elec_time_code = state_reg.elec_time[state_reg.elec];
        if (elec_time_code == 3'd0) begin
            elec_time_code = state_reg.filter_config[CHARGE_TIME_MSB:CHARGE_TIME_LSB]; // R12
        end
        elec_cur_code = state_reg.elec_current[state_reg.elec];
        if (elec_cur_code == 6'd0) begin
            elec_cur_code = state_reg.front_end_config[CURRENT_MSB:CURRENT_LSB]; // R11
        end

        interval_cycles = 32'(INTERVAL_BASE_CYCLES_P)
                          << state_reg.filter_config[INTERVAL_MSB:INTERVAL_LSB]; // R10 R13

        state_next.ffi_count = FIRST_FILTER_COUNTS[state_reg.front_end_config[FIRST_FILTER_MSB:FIRST_FILTER_LSB]]; // R6
        state_next.sfi_count = SECOND_FILTER_COUNTS[state_reg.filter_config[SECOND_FILTER_MSB:SECOND_FILTER_LSB]]; // R9

        // sample interval tick; a tick during a scan waits as pending
        tick = (state_reg.interval >= interval_cycles - 32'd1);
        if (tick) begin
            state_next.interval = 32'd0;
            state_next.pending  = 1'b1;
        end else begin
            state_next.interval = state_reg.interval + 32'd1;
        end

        // register writes
        if (reg_write) begin
            if (reg_addr == ADDR_FRONT_END) begin
                state_next.front_end_config = reg_wdata; // R5 R7
            end else if (reg_addr == ADDR_FILTER) begin
                state_next.filter_config = reg_wdata;
            end else if (in_block(reg_addr, ADDR_ELEC_CUR_BASE, NUM_ELEC)) begin
                state_next.elec_current[block_idx(reg_addr, ADDR_ELEC_CUR_BASE)] = reg_wdata[5:0];
            end else if (in_block(reg_addr, ADDR_ELEC_TIM_BASE, NUM_ELEC)) begin
                state_next.elec_time[block_idx(reg_addr, ADDR_ELEC_TIM_BASE)] = reg_wdata[2:0];
            end
        end

        // register reads, answered one cycle later
        if (reg_read) begin
            state_next.rdata = 8'h00;
            if (reg_addr == ADDR_STATUS) begin
                state_next.rdata = {state_reg.st != ST_IDLE, state_reg.pending, 2'b00, state_reg.elec};
            end else if (reg_addr == ADDR_FRONT_END) begin
                state_next.rdata = state_reg.front_end_config;
            end else if (reg_addr == ADDR_FILTER) begin
                state_next.rdata = state_reg.filter_config;
            end else if (in_block(reg_addr, ADDR_ELEC_CUR_BASE, NUM_ELEC)) begin
                state_next.rdata = {2'b00, state_reg.elec_current[block_idx(reg_addr, ADDR_ELEC_CUR_BASE)]};
            end else if (in_block(reg_addr, ADDR_ELEC_TIM_BASE, NUM_ELEC)) begin
                state_next.rdata = {5'h00, state_reg.elec_time[block_idx(reg_addr, ADDR_ELEC_TIM_BASE)]};
            end else if (in_block(reg_addr, ADDR_SAMPLE_BASE, 2 * NUM_ELEC)) begin
                sample_off = reg_addr - ADDR_SAMPLE_BASE;
                sample_idx = sample_off[4:1];
                state_next.rdata = sample_off[0] ? {6'h00, state_reg.samples[sample_idx][9:8]}
                                                 : state_reg.samples[sample_idx][7:0];
            end
        end

        // measurement sequence
        if (state_reg.timer != 16'd0) begin
            state_next.timer = state_reg.timer - 16'd1;
        end
        case (state_reg.st)
            ST_IDLE: begin
                state_next.ground    = '1; // R2
                state_next.charge    = 1'b0;
                state_next.discharge = 1'b0;
                if (state_reg.pending) begin
                    state_next.pending = tick; // a tick on the taking cycle is kept
                    state_next.elec    = 4'd0;
                    state_next.timer   = 16'(GROUND_CYCLES - 1);
                    state_next.st      = ST_GROUND;
                end
            end
            ST_GROUND: begin
                state_next.ground = '1; // R1
                if (state_reg.timer == 16'd0) begin
                    state_next.phase_cycles = charge_cycles(elec_time_code);
                    state_next.timer        = charge_cycles(elec_time_code) - 16'd1;
                    state_next.current      = elec_cur_code;
                    state_next.ground       = ~(NUM_ELEC'(1) << state_reg.elec); // R2
                    // zero current: phases still time out and the conversion still runs; charge_en and discharge_en stay low
                    state_next.charge       = (elec_cur_code != 6'd0); // R1 R7
                    state_next.st           = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (state_reg.timer == 16'd0) begin
                    state_next.charge = 1'b0;
                    state_next.start  = 1'b1; // R3
                    state_next.st     = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (cv.done) begin
                    state_next.samples[state_reg.elec] = cv.sample; // R3
                    state_next.timer     = state_reg.phase_cycles - 16'd1; // R4
                    state_next.discharge = (state_reg.current != 6'd0); // R4
                    state_next.st        = ST_DISCHARGE;
                end
            end
            ST_DISCHARGE: begin
                if (state_reg.timer == 16'd0) begin
                    state_next.discharge = 1'b0;
                    state_next.ground    = '1;
                    if (32'(state_reg.elec) == NUM_ELEC - 1) begin
                        state_next.done = 1'b1;
                        state_next.st   = ST_IDLE;
                    end else begin
                        state_next.elec  = state_reg.elec + 4'd1; // R14
                        state_next.timer = 16'(GROUND_CYCLES - 1);
                        state_next.st    = ST_GROUND;
                    end
                end
            end
            default: begin
                state_next.st     = ST_IDLE;
                state_next.ground = '1;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg                  <= '0;
            state_reg.st               <= ST_IDLE;
            state_reg.ground           <= '1;
            state_reg.front_end_config <= FRONT_END_RESET;
            state_reg.filter_config    <= FILTER_RESET;
            state_reg.ffi_count        <= FIRST_FILTER_COUNTS[FRONT_END_RESET[FIRST_FILTER_MSB:FIRST_FILTER_LSB]];
            state_reg.sfi_count        <= SECOND_FILTER_COUNTS[FILTER_RESET[SECOND_FILTER_MSB:SECOND_FILTER_LSB]];
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign cv.start                   = state_reg.start;
    assign reg_rdata                  = state_reg.rdata;
    assign elec_ground                = state_reg.ground;
    assign elec_select                = state_reg.elec;
    assign charge_en                  = state_reg.charge;
    assign discharge_en               = state_reg.discharge;
    assign charge_current_select      = state_reg.current; // R7
    assign first_filter_sample_count  = state_reg.ffi_count;
    assign second_filter_sample_count = state_reg.sfi_count;
    assign scan_done                  = state_reg.done;

endmodule : cap_measure

// *** verilog/cap_measure_pkg.sv ***
/*
 * constants for the electrode charge/measure front end: register map,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz clock.
 */
package cap_measure_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS          = 10;
    localparam int CHARGE_TIME_BASE_NS    = 500;
    localparam int CHARGE_BASE_CYCLES     = (CHARGE_TIME_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GROUND_TIME_NS         = 500;
    localparam int GROUND_CYCLES          = (GROUND_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_INTERVAL_BASE_MS = 1;
    localparam int INTERVAL_BASE_CYCLES   = SAMPLE_INTERVAL_BASE_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_STATUS        = 8'h00;
    localparam logic [7:0] ADDR_SAMPLE_BASE   = 8'h04;
    localparam logic [7:0] ADDR_FRONT_END     = 8'h5c;
    localparam logic [7:0] ADDR_FILTER        = 8'h5d;
    localparam logic [7:0] ADDR_ELEC_CUR_BASE = 8'h5f;
    localparam logic [7:0] ADDR_ELEC_TIM_BASE = 8'h6c;

    // ==========================================================
    // reset values
    localparam logic [7:0] FRONT_END_RESET = 8'h10;
    localparam logic [7:0] FILTER_RESET    = 8'h24;

    // ==========================================================
    // field positions
    localparam int FIRST_FILTER_MSB  = 7;
    localparam int FIRST_FILTER_LSB  = 6;
    localparam int CURRENT_MSB       = 5;
    localparam int CURRENT_LSB       = 0;
    localparam int CHARGE_TIME_MSB   = 7;
    localparam int CHARGE_TIME_LSB   = 5;
    localparam int SECOND_FILTER_MSB = 4;
    localparam int SECOND_FILTER_LSB = 3;
    localparam int INTERVAL_MSB      = 2;
    localparam int INTERVAL_LSB      = 0;

    // ==========================================================
    // filter sample counts per code
    localparam logic [5:0] FIRST_FILTER_COUNTS [4]  = '{6'd6, 6'd10, 6'd18, 6'd34};
    localparam logic [5:0] SECOND_FILTER_COUNTS [4] = '{6'd4, 6'd6, 6'd10, 6'd18};

    // ==========================================================
    // measurement sequence, gray coded along the path
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_GROUND    = 3'b001,
        ST_CHARGE    = 3'b011,
        ST_CONVERT   = 3'b010,
        ST_DISCHARGE = 3'b110
    } meas_state_t;

endpackage : cap_measure_pkg

// *** verilog/conv_if.sv ***
/*
 * carrier between the sequencer and the converter capture block.
 * assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface conv_if;
    logic       start;
    logic       done;
    logic [9:0] sample;

    modport ctrl (output start, input  done, input  sample);
    modport conv (input  start, output done, output sample);
endinterface : conv_if

// *** verilog/conv_capture.sv ***
/*
 * converter capture: drives the start pin and picks up the 10-bit result.
 * assumes done and data pins are asynchronous; data stable while done high.
 */
`timescale 1ns/1ps
module conv_capture
    import cap_measure_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // sequencer side
    conv_if.conv            cv,
    // converter pins
    output logic            adc_start,
    input  wire logic       adc_done,
    input  wire logic [9:0] adc_data
);

    typedef struct packed {
        logic       start;
        logic       done_s1;
        logic       done_s2;
        logic       done_d;
        logic [9:0] data_s1;
        logic [9:0] data_s2;
        logic       done;
        logic [9:0] sample;
    } cap_state_t;

    cap_state_t state_reg;
    cap_state_t state_next;

    // ==========================================================
    // next state
    always_comb begin
        state_next         = state_reg;
        state_next.start   = cv.start;
        state_next.done_s1 = adc_done;
        state_next.done_s2 = state_reg.done_s1;
        state_next.done_d  = state_reg.done_s2;
        state_next.data_s1 = adc_data;
        state_next.data_s2 = state_reg.data_s1;
        // rising edge only, so a long done level counts once
        state_next.done    = state_reg.done_s2 & ~state_reg.done_d;
        if (state_reg.done_s2 & ~state_reg.done_d) begin
            state_next.sample = state_reg.data_s2; // R3
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign adc_start = state_reg.start;
    assign cv.done   = state_reg.done;
    assign cv.sample = state_reg.sample;

endmodule : conv_capture

// *** bench/cap_measure_asserts.sv ***
/* checker for the measurement sequencer ports.
   assumes one clock, synchronous reset; bound to cap_measure below. */
`timescale 1ns/1ps
module cap_measure_asserts
    import cap_measure_pkg::*;
#(
    parameter int NUM_ELEC = 12
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                reset,
    // electrode side
    input wire logic [NUM_ELEC-1:0] elec_ground,
    input wire logic [3:0]          elec_select,
    input wire logic                charge_en,
    input wire logic                discharge_en,
    input wire logic [5:0]          charge_current_select,
    input wire logic                adc_start,
    // settings and status
    input wire logic [5:0]          first_filter_sample_count,
    input wire logic [5:0]          second_filter_sample_count,
    input wire logic                scan_done
);
    // ==========
    // helper counters
    logic [NUM_ELEC-1:0] mask;
    logic [11:0]         chg_reg;
    logic [11:0]         dis_reg;
    logic [11:0]         last_reg;
    assign mask = ~({{(NUM_ELEC-1){1'b0}}, 1'b1} << elec_select);
    always_ff @(posedge clk) begin
        if (reset) begin
            chg_reg  <= 12'h000;
            dis_reg  <= 12'h000;
            last_reg <= 12'h000;
        end else begin
            chg_reg <= charge_en ? chg_reg + 12'h001 : 12'h000;
            dis_reg <= discharge_en ? dis_reg + 12'h001 : 12'h000;
            if (!charge_en && chg_reg != 12'h000) last_reg <= chg_reg;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence charge_begin; $rose(charge_en); endsequence
    sequence charge_end; $fell(charge_en); endsequence
    sequence discharge_end; $fell(discharge_en); endsequence
    mask_held_a: assert property ((charge_en || discharge_en) |-> elec_ground == mask)
        else $error("electrode mask wrong while active");
    ground_first_a: assert property (charge_begin |-> $past(elec_ground) == '1)
        else $error("charge began without ground phase");
    charge_len_a: assert property (charge_end |-> chg_reg inside {12'h032, 12'h064, 12'h0c8,
        12'h190, 12'h320, 12'h640, 12'hc80}) else $error("charge length off");
    discharge_len_a: assert property (discharge_end |-> dis_reg == last_reg)
        else $error("discharge length differs from charge");
    convert_after_a: assert property (charge_end |-> ##[0:4] adc_start)
        else $error("no conversion after charge");
    start_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("start pulse too long");
    phase_excl_a: assert property (!(charge_en && discharge_en))
        else $error("charge and discharge together");
    zero_current_a: assert property (charge_current_select == 6'h00 |-> !charge_en && !discharge_en)
        else $error("current source on at code zero");
    filter_counts_a: assert property (first_filter_sample_count inside {6'h06, 6'h0a, 6'h12, 6'h22}
        && second_filter_sample_count inside {6'h04, 6'h06, 6'h0a, 6'h12}) else $error("bad filter count");
    done_pulse_a: assert property (scan_done |-> (elec_ground == '1 && !discharge_en) ##1 !scan_done)
        else $error("scan done not a single idle pulse");
endmodule : cap_measure_asserts
bind cap_measure cap_measure_asserts #(.NUM_ELEC(NUM_ELEC)) i_chk (
    .clk(clk), .reset(reset), .elec_ground(elec_ground), .elec_select(elec_select),
    .charge_en(charge_en), .discharge_en(discharge_en), .charge_current_select(charge_current_select),
    .adc_start(adc_start), .first_filter_sample_count(first_filter_sample_count),
    .second_filter_sample_count(second_filter_sample_count), .scan_done(scan_done)
);

// *** bench/adc_model.sv ***
/* converter model: answers a start pulse with a 10-bit result.
   assumes the bench supplies per-electrode values and the answer delay. */
`timescale 1ns/1ps
module adc_model (
    // clock
    input wire logic         clk,
    // converter pins
    input wire logic         adc_start,
    output logic             adc_done,
    output logic [9:0]       adc_data,
    // bench stimulus
    input wire logic [3:0]   elec_select,
    input wire logic [119:0] vals,
    input wire logic [4:0]   delay
);
    logic [9:0] v;
    initial begin
        adc_done = 1'b0;
        adc_data = 10'h2aa;
        forever begin
            @(negedge clk);
            if (adc_start === 1'b1) begin
                v = vals[elec_select*10 +: 10];
                repeat (delay) @(posedge clk);
                adc_data <= v;
                // data settles a cycle before done, held while done high
                @(posedge clk);
                adc_done <= 1'b1;
                repeat (6) @(posedge clk);
                adc_done <= 1'b0;
                @(posedge clk);
                // released: never leave the old value readable
                adc_data <= ~v;
            end
        end
    end
endmodule : adc_model

// *** bench/testbench.sv ***
/* bench: register access, scan phases and order, samples, interval.
   assumes adc_model as converter and the bound checker. */
`timescale 1ns/1ps
module testbench
    import cap_measure_pkg::*;
;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic         reg_write = 1'b0, reg_read = 1'b0;
    logic [11:0]  elec_ground;
    logic [3:0]   elec_select;
    logic         charge_en, discharge_en, adc_start, adc_done, scan_done;
    logic [5:0]   cur_sel, ffc, sfc;
    logic [9:0]   adc_data;
    logic [119:0] vals = '0;
    logic [4:0]   delay = 5'h03;
    int           errors = 0, checked = 0, cc = 0, dc = 0, i;
    int           cq[$], dq[$];
    logic [3:0]   eq[$];
    time          t0;
    always #5 clk = ~clk;
    // interval shortened to 200 cycles per millisecond step
    cap_measure #(.NUM_ELEC(12), .INTERVAL_BASE_CYCLES_P(200)) i_dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .elec_ground(elec_ground), .elec_select(elec_select), .charge_en(charge_en),
        .discharge_en(discharge_en), .charge_current_select(cur_sel), .adc_start(adc_start),
        .adc_done(adc_done), .adc_data(adc_data), .first_filter_sample_count(ffc),
        .second_filter_sample_count(sfc), .scan_done(scan_done));
    adc_model i_adc (.clk(clk), .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
        .elec_select(elec_select), .vals(vals), .delay(delay));
    // ==========
    // phase length monitor
    always @(negedge clk) begin
        if (charge_en === 1'b1) cc++;
        else if (cc != 0) begin
            cq.push_back(cc);
            eq.push_back(elec_select);
            cc = 0;
        end
        if (discharge_en === 1'b1) dc++;
        else if (dc != 0) begin
            dq.push_back(dc);
            dc = 0;
        end
    end
    // ==========
    // tasks
    task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        chk_cnt({24'h000000, got}, {24'h000000, exp});
    endtask : chk_reg
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (scan_done !== 1'b1 && n < 20000);
        if (n >= 20000) chk_cnt(n, 0);
    endtask : wait_done
    function automatic int tcyc(input int c);
        return CHARGE_BASE_CYCLES << ((c == 0 ? 1 : c) - 1);
    endfunction : tcyc
    // one full scan with global time tc, override oc on electrode oe
    task automatic run_scan(input int tc, input int oe, input int oc, input logic [5:0] cur);
        int n;
        for (n = 0; n < 12; n++) vals[n*10 +: 10] = 10'($urandom);
        delay = 5'($urandom_range(1, 20));
        wr(8'h5c, {2'b00, cur});
        wr(8'h5d, {tc[2:0], 5'h00});
        wr(8'(8'h6c + oe), oc[7:0]);
        wait_done();
        @(negedge clk); // let the monitor log the last discharge first
        cq.delete();
        dq.delete();
        eq.delete();
        wait_done();
        chk_cnt(cq.size(), (cur == 6'h00) ? 0 : 12);
        chk_cnt({26'h0, cur_sel}, {26'h0, cur});
        for (n = 0; n < 12; n++) begin
            if (cur != 6'h00) begin
                chk_cnt({28'h0000000, eq[n]}, n);
                chk_cnt(cq[n], tcyc((n == oe && oc != 0) ? oc : tc));
                chk_cnt(dq[n], cq[n]);
            end
            rd(8'(8'h04 + 2 * n), rv);
            chk_reg(rv, vals[n*10 +: 8]);
            rd(8'(8'h05 + 2 * n), rv);
            chk_reg(rv, {6'h00, vals[n*10+8 +: 2]});
        end
        wr(8'(8'h6c + oe), 8'h00);
    endtask : run_scan
    task automatic print_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // ==========
    // watchdog: tests need about 50000 cycles
    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        print_verdict();
    end
    // ==========
    // main sequence
    initial begin
        void'($urandom(32'h43be));
        repeat (16) @(negedge clk);
        reset = 1'b0;
        rd(8'h5c, rv);
        chk_reg(rv, FRONT_END_RESET);
        rd(8'h5d, rv);
        chk_reg(rv, FILTER_RESET);
        rd(8'hf0, rv);
        chk_reg(rv, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(8'h5c, {i[1:0], 6'h15});
            wr(8'h5d, {3'h1, i[1:0], 3'h0});
            rd(8'h5c, rv);
            chk_reg(rv, {i[1:0], 6'h15});
            chk_cnt({26'h0, ffc}, 2 + (4 << i));
            chk_cnt({26'h0, sfc}, 2 + (2 << i));
        end
        run_scan(1, 0, 0, 6'($urandom_range(1, 63)));
        run_scan(0, 2, 2, 6'h3f);
        run_scan(3, 11, 1, 6'h01);
        run_scan(1, 5, 0, 6'h00);
        wr(8'h5c, 8'h0a);
        delay = 5'h04;
        for (i = 4; i < 6; i++) begin
            wr(8'h5d, {3'h1, 2'b00, i[2:0]});
            // start timing only after a scan that began from idle on a tick
            do begin
                wait_done();
                rd(8'h00, rv);
            end while (rv[7] === 1'b1);
            wait_done();
            t0 = $time;
            wait_done();
            chk_cnt(32'(($time - t0) / 10), 200 << i);
        end
        print_verdict();
    end
endmodule : testbench
